//--- logic/dac_ctl_pkg.sv
/*
 package for the converter register control block: addresses, control field positions,
 range codes, status bit positions, code constants and slew timing.
 assumes a 16-bit code path; the 12-bit variant is handled by parameter in the module.
*/
package dac_ctl_pkg;
   // address bytes of the serial word
   localparam logic [7:0] ADDR_NOP = 8'h00;
   localparam logic [7:0] ADDR_DATA = 8'h01;
   localparam logic [7:0] ADDR_READ = 8'h02;
   localparam logic [7:0] ADDR_CONFIG = 8'h55;
   localparam logic [7:0] ADDR_RESTART = 8'h56;
   // serial word layout
   localparam int WORD_BITS = 24;
   localparam int ADDR_HI = 23;
   localparam int ADDR_LO = 16;
   // control field positions
   localparam int ZSEL_BIT = 15;
   localparam int WIDEN_BIT = 14;
   localparam int EXT_RESISTOR_SELECT_BIT = 13;
   localparam int OEN_BIT = 12;
   localparam int RATE_HI = 11;
   localparam int RATE_LO = 8;
   localparam int STEP_HI = 7;
   localparam int STEP_LO = 5;
   localparam int RAMP_BIT = 4;
   localparam int CHAIN_BIT = 3;
   localparam int RANGE_HI = 2;
   localparam int RANGE_LO = 0;
   localparam int RESTART_BIT = 0;
   // status bit positions
   localparam int ST_LOOP_BIT = 2;
   localparam int ST_RAMP_BIT = 1;
   localparam int ST_HOT_BIT = 0;
   // range codes
   localparam logic [2:0] RNG_U5 = 3'h0;
   localparam logic [2:0] RNG_U10 = 3'h1;
   localparam logic [2:0] RNG_B5 = 3'h2;
   localparam logic [2:0] RNG_B10 = 3'h3;
   localparam logic [2:0] RNG_BAD = 3'h4;
   localparam logic [2:0] RNG_I420 = 3'h5;
   localparam logic [2:0] RNG_I020 = 3'h6;
   localparam logic [2:0] RNG_I024 = 3'h7;
   // code values
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_MID = 16'h8000;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   // readback selects
   localparam logic [1:0] RD_STATUS = 2'h0;
   localparam logic [1:0] RD_DATA = 2'h1;
   localparam logic [1:0] RD_CONFIG = 2'h2;
   // slew update rates in hertz, indexed by rate field
   localparam int CLK_HZ = 50_000_000;
   localparam int RATE_HZ [16] = '{257730, 198410, 152440, 131580, 115740, 69440, 37590, 25770,
                                   20160, 16030, 10290, 8280, 6900, 5530, 4240, 3300};
   // longest period in clock cycles, round down
   localparam int RATE_MAX_CYC = CLK_HZ / 3300;
endpackage

//--- logic/dac_ctl.sv
/*
 register control for a single-channel voltage/current output converter: serial word
 capture on the link clock, control/data/restart/status registers, clear handling,
 slew limiting, fault alarm.
 assumes the host frames 24 rising SCLK edges then raises LATCH; fault and temperature
 detectors and clear pins arrive asynchronously from the analog side.

 link side, clocked by SCLK and LATCH:
 - rising SCLK shifts SDIN into a 24-bit word, msb first
 - an edge counter tells a full word from a short or long one
 - a LATCH pulse with no SCLK edges at all is an empty latch
 - the latched word and its kind cross by a single toggle
 - readback leaves on SDO as an 8-bit zero head and 16 data bits
 - SDO_OE rises with the read word's LATCH, falls with the next one

 system side, clocked by CLK:
 - the toggle passes two flip-flops, a third stage finds its edge
 - word fields are read only on that edge, when they are long settled
 - clear, clear select and both detectors pass two flip-flops
 - the output moves at once, or in timed steps with ramp enable set
 - a control write stops a running ramp for one clock where it stands and restarts its timer
 - restart behaves as RST for the registers of the update block, not for the status flags or the slew timer

 hazards a user must know:
 - words closer than five CLK periods apart may be lost
 - link state has no reset; the first LATCH pulse sets it up
 - the readback word must be steady before the next frame starts
 - clear that is shorter than the synchroniser may be missed
 - range code 100 leaves both outputs disabled
 - ramp timing counts CLK cycles, so it follows the CLK rate
*/
`timescale 1ns/1ps
module dac_ctl #(
   parameter int CODE_BITS = 16
) (
   // system
   input wire logic CLK,
   input wire logic RST,
   // serial link
   input wire logic SCLK,
   input wire logic SDIN,
   input wire logic LATCH,
   output logic SDO,
   output logic SDO_OE,
   // clear pins
   input wire logic CLEAR,
   input wire logic CLEAR_SELECT,
   // analog detectors
   input wire logic LOOP_FAULT_IN,
   input wire logic OVERTEMP_IN,
   // alarm pin, open drain
   output logic FAULT_N_O,
   output logic FAULT_N_OE,
   // analog controls
   output logic [15:0] OUT_CODE,
   output logic VOLTAGE_EN,
   output logic CURRENT_EN,
   output logic [2:0] OUT_RANGE,
   output logic RANGE_WIDEN,
   output logic EXT_RESISTOR,
   output logic BIPOLAR
);
   initial begin
      if (CODE_BITS != 12 && CODE_BITS != 16) $error("CODE_BITS must be 12 or 16");
   end

   // ---------------- link domain ----------------
   logic [23:0] shift_r;           // input shift register
   logic [23:0] word_r;            // word latched on LATCH rise
   logic [5:0] edge_cnt_r = 6'h00; // rising edges since last latch
   logic word_ok_r;                // latched word had exactly 24 edges
   logic word_empty_r;             // latched word had no edges at all
   logic word_tgl_r = 1'b0;        // toggles per latched word, known from the start
   logic [23:0] sdo_shift_r;       // readback word on SDO, zero head then data
   logic sdo_oe_r = 1'b0;          // SDO drive
   logic [15:0] rd_word_x;         // readback word from core, quasi-static

   // shift serial data in on SCLK rising edge
   always_ff @(posedge SCLK or posedge LATCH) begin
      if (LATCH) begin
         edge_cnt_r <= 6'h00;
      end else begin
         shift_r <= {shift_r[22:0], SDIN};
         if (edge_cnt_r != 6'h3f) edge_cnt_r <= edge_cnt_r + 6'h01;
      end
   end

   // latch rising edge: capture the word and hand it across
   always_ff @(posedge LATCH) begin
      word_r <= shift_r;
      word_ok_r <= (edge_cnt_r == 6'(dac_ctl_pkg::WORD_BITS));
      word_empty_r <= (edge_cnt_r == 6'h00);
      word_tgl_r <= ~word_tgl_r;
      // a valid read word enables SDO for the frame that follows
      sdo_oe_r <= (shift_r[dac_ctl_pkg::ADDR_HI:dac_ctl_pkg::ADDR_LO] == dac_ctl_pkg::ADDR_READ)
                  && (edge_cnt_r == 6'(dac_ctl_pkg::WORD_BITS));
   end

   // readback: cleared at LATCH, loaded at the first falling SCLK of a frame,
   // when the read select has long since landed; rd_word_x is quasi-static then
   always_ff @(negedge SCLK or posedge LATCH) begin
      if (LATCH) sdo_shift_r <= 24'h00_0000;
      else if (edge_cnt_r == 6'h01) sdo_shift_r <= {7'h00, rd_word_x, 1'b0};
      else sdo_shift_r <= {sdo_shift_r[22:0], 1'b0};
   end

   assign SDO = sdo_shift_r[23];
   assign SDO_OE = sdo_oe_r;

   // crossing notes
   // the link side owns word_r, word_ok_r and word_empty_r; they change only at
   // the LATCH rise, together with the toggle, so by the time the toggle edge
   // reaches the third stage here every word bit has stood still for two clocks
   // and may be read without a synchroniser of its own.
   // only one word is in flight: a second LATCH inside the settling time would
   // overwrite the first before it is read, so words are kept apart by the host.
   // the readback word goes the other way; it is read on falling SCLK well after
   // the read select has been written, and it does not change during the frame
   // unless a detector or a ramp moves the status bits, which the user accepts.
   // empty latches carry no data and only matter when a clear has been seen.
   // the counter saturates so that a runaway clock never wraps into 24 again.
   //
   // output path notes
   // target_r is where the output heads, out_r is where it is.
   // with ramp enable clear the output follows the target one clock later.
   // with ramp enable set, each tick moves it one step toward the target and
   // never past it; a control write holds the output where it stands.
   // a clear replaces the target but keeps the old one in held_r, once only,
   // so a long clear does not overwrite the value to be restored.
   // range changes and enable rises reload the target with the default value
   // of the new setting, taking the clear select pin into account.
   //
   // status notes
   // status bits are copies of hardware conditions, one clock behind them;
   // no host word reaches them, and a restart leaves them to the detectors.
   // the alarm enable is the or of the two registered fault bits, with no register of its own.
   //
   // ---------------- system domain ----------------
   typedef enum logic [1:0] {
      RAMP_IDLE = 2'b00,
      RAMP_RUN = 2'b01
   } ramp_state_t;

   logic [2:0] tgl_sync_r;          // toggle synchroniser plus edge stage
   logic [1:0] clr_sync_r, csel_sync_r, loop_sync_r, hot_sync_r;
   logic [15:0] cfg_r, cfg_nxt;     // output_configuration
   logic [15:0] code_r, code_nxt;   // output_code, the programmed value
   logic [15:0] out_r, out_nxt;     // value at the converter
   logic [15:0] target_r, target_nxt; // value the output heads for
   logic [15:0] held_r, held_nxt;   // pre-clear value
   logic [2:0] status_r;            // condition_flags
   logic [1:0] rd_sel_r;            // readback select
   logic [23:0] rate_cnt_r;         // slew update timer
   ramp_state_t ramp_r, ramp_nxt;
   logic clr_seen_r;                // clear has forced the output
   logic oen_d_r;                   // previous output enable

   // word decode
   wire new_word = tgl_sync_r[2] ^ tgl_sync_r[1];
   wire [7:0] w_addr = word_r[dac_ctl_pkg::ADDR_HI:dac_ctl_pkg::ADDR_LO];
   wire [15:0] w_data = word_r[15:0];
   wire good_word = new_word && word_ok_r;
   wire empty_latch = new_word && word_empty_r;
   wire wr_cfg = good_word && (w_addr == dac_ctl_pkg::ADDR_CONFIG);
   wire wr_data = good_word && (w_addr == dac_ctl_pkg::ADDR_DATA);
   wire wr_rd = good_word && (w_addr == dac_ctl_pkg::ADDR_READ);
   wire restart = good_word && (w_addr == dac_ctl_pkg::ADDR_RESTART)
                  && w_data[dac_ctl_pkg::RESTART_BIT];
   wire clr = clr_sync_r[1];
   wire [15:0] cfg_new = wr_cfg ? w_data : cfg_r;

   // data alignment by variant
   wire [15:0] data_code = (CODE_BITS == 12) ? {w_data[15:4], 4'h0} : w_data;

   // control fields
   wire [2:0] range = cfg_r[dac_ctl_pkg::RANGE_HI:dac_ctl_pkg::RANGE_LO];
   wire oen = cfg_r[dac_ctl_pkg::OEN_BIT];
   wire ramp_en = cfg_r[dac_ctl_pkg::RAMP_BIT];
   wire [3:0] rate_sel = cfg_r[dac_ctl_pkg::RATE_HI:dac_ctl_pkg::RATE_LO];
   wire [2:0] step_sel = cfg_r[dac_ctl_pkg::STEP_HI:dac_ctl_pkg::STEP_LO];
   wire zsel = csel_sync_r[1] | cfg_r[dac_ctl_pkg::ZSEL_BIT];

   // default / clear value for a range and select
   function automatic logic [15:0] clear_code(input logic [2:0] rng, input logic sel);
      logic is_bip;
      is_bip = (rng == dac_ctl_pkg::RNG_B5) || (rng == dac_ctl_pkg::RNG_B10);
      if (rng[2]) clear_code = dac_ctl_pkg::CODE_ZERO;
      else if (!sel) clear_code = is_bip ? dac_ctl_pkg::CODE_MID : dac_ctl_pkg::CODE_ZERO;
      else clear_code = is_bip ? dac_ctl_pkg::CODE_ZERO : dac_ctl_pkg::CODE_MID;
   endfunction

   // step size: doubles per step code; the same for the 12-bit and the 16-bit variant
   function automatic logic [15:0] step_size(input logic [2:0] s);
      step_size = 16'h0001 << s;
   endfunction

   wire [15:0] clr_val = clear_code(range, zsel);
   wire range_chg = wr_cfg && (w_data[dac_ctl_pkg::RANGE_HI:dac_ctl_pkg::RANGE_LO] != range);
   wire oen_rise = cfg_r[dac_ctl_pkg::OEN_BIT] && !oen_d_r;
   wire [15:0] def_new = clear_code(cfg_new[dac_ctl_pkg::RANGE_HI:dac_ctl_pkg::RANGE_LO],
                                    csel_sync_r[1] | cfg_new[dac_ctl_pkg::ZSEL_BIT]);
   wire [23:0] rate_cyc = 24'(dac_ctl_pkg::CLK_HZ / dac_ctl_pkg::RATE_HZ[rate_sel]);
   wire tick = (rate_cnt_r >= rate_cyc - 24'h000001);
   wire [15:0] stp = step_size(step_sel);
   wire [16:0] up = {1'b0, out_r} + {1'b0, stp};
   wire [16:0] dn = {1'b0, out_r} - {1'b0, stp};

   // synchronisers for async inputs and the word toggle
   always_ff @(posedge CLK) begin
      tgl_sync_r <= {tgl_sync_r[1:0], word_tgl_r};
      clr_sync_r <= {clr_sync_r[0], CLEAR};
      csel_sync_r <= {csel_sync_r[0], CLEAR_SELECT};
      loop_sync_r <= {loop_sync_r[0], LOOP_FAULT_IN};
      hot_sync_r <= {hot_sync_r[0], OVERTEMP_IN};
   end

   // register and target selection
   always_comb begin
      cfg_nxt = cfg_new;
      code_nxt = (wr_data && !clr) ? data_code : code_r;
      held_nxt = held_r;
      target_nxt = target_r;
      if (clr) begin
         target_nxt = clr_val;
         if (!clr_seen_r) held_nxt = target_r;
      end else if (empty_latch && clr_seen_r) begin
         target_nxt = held_r;
      end else if (range_chg || oen_rise) begin
         target_nxt = def_new;
      end else if (wr_data) begin
         target_nxt = data_code;
      end
   end

   // output movement, immediate or slewed
   always_comb begin
      out_nxt = out_r;
      ramp_nxt = ramp_r;
      if (!ramp_en || wr_cfg) begin
         out_nxt = wr_cfg ? out_r : target_r;
         ramp_nxt = RAMP_IDLE;
      end else begin
         case (ramp_r)
            RAMP_IDLE: begin
               if (out_r != target_r) ramp_nxt = RAMP_RUN;
            end
            RAMP_RUN: begin
               if (out_r == target_r) ramp_nxt = RAMP_IDLE;
               else if (tick) begin
                  if (target_r > out_r) out_nxt = (up[16] || up[15:0] > target_r) ? target_r : up[15:0];
                  else out_nxt = (dn[16] || dn[15:0] < target_r) ? target_r : dn[15:0];
               end
            end
            default: ramp_nxt = RAMP_IDLE;
         endcase
      end
   end

   // register update; restart behaves as reset
   always_ff @(posedge CLK) begin
      if (RST || restart) begin
         cfg_r <= dac_ctl_pkg::RESET_WORD;
         code_r <= dac_ctl_pkg::RESET_WORD;
         out_r <= dac_ctl_pkg::RESET_WORD;
         target_r <= dac_ctl_pkg::RESET_WORD;
         held_r <= dac_ctl_pkg::RESET_WORD;
         ramp_r <= RAMP_IDLE;
         clr_seen_r <= 1'b0;
         oen_d_r <= 1'b0;
         rd_sel_r <= dac_ctl_pkg::RD_STATUS;
      end else begin
         cfg_r <= cfg_nxt;
         code_r <= code_nxt;
         out_r <= out_nxt;
         target_r <= target_nxt;
         held_r <= held_nxt;
         ramp_r <= ramp_nxt;
         clr_seen_r <= clr ? 1'b1 : (empty_latch ? 1'b0 : clr_seen_r);
         oen_d_r <= oen;
         if (wr_rd) rd_sel_r <= w_data[1:0];
      end
   end

   // slew update timer
   always_ff @(posedge CLK) begin
      if (RST || tick || ramp_r == RAMP_IDLE) rate_cnt_r <= 24'h000000;
      else rate_cnt_r <= rate_cnt_r + 24'h000001;
   end

   // status flags, hardware only, no host write path
   always_ff @(posedge CLK) begin
      if (RST) status_r <= 3'h0;
      else begin
         status_r[dac_ctl_pkg::ST_LOOP_BIT] <= loop_sync_r[1];
         status_r[dac_ctl_pkg::ST_RAMP_BIT] <= (ramp_nxt == RAMP_RUN);
         status_r[dac_ctl_pkg::ST_HOT_BIT] <= hot_sync_r[1];
      end
   end

   // readback word, data and config stable between words, status follows its flags
   assign rd_word_x = (rd_sel_r == dac_ctl_pkg::RD_DATA) ? code_r :
                      (rd_sel_r == dac_ctl_pkg::RD_CONFIG) ? cfg_r : {13'h0000, status_r};

   // analog side controls
   assign OUT_CODE = out_r;
   assign OUT_RANGE = range;
   assign VOLTAGE_EN = oen && !range[2];
   assign CURRENT_EN = oen && range[2] && (range != dac_ctl_pkg::RNG_BAD);
   assign RANGE_WIDEN = cfg_r[dac_ctl_pkg::WIDEN_BIT];
   assign EXT_RESISTOR = cfg_r[dac_ctl_pkg::EXT_RESISTOR_SELECT_BIT];
   assign BIPOLAR = (range == dac_ctl_pkg::RNG_B5) || (range == dac_ctl_pkg::RNG_B10);
   // alarm: drive low only
   assign FAULT_N_O = 1'b0;
   assign FAULT_N_OE = status_r[dac_ctl_pkg::ST_LOOP_BIT] | status_r[dac_ctl_pkg::ST_HOT_BIT];
endmodule

//--- tb/dac_ctl_sva.sv
/*
 checker for the converter register control block: alarm pin, output type, clear and enable defaults.
 assumes it is bound to every dac_ctl instance and samples on CLK.
*/
`timescale 1ns/1ps
module dac_ctl_sva (
   // system
   input wire logic CLK,
   input wire logic RST,
   // pins
   input wire logic CLEAR,
   input wire logic CLEAR_SELECT,
   input wire logic LOOP_FAULT_IN,
   input wire logic OVERTEMP_IN,
   input wire logic FAULT_N_O,
   input wire logic FAULT_N_OE,
   // analog controls
   input wire logic [15:0] OUT_CODE,
   input wire logic VOLTAGE_EN,
   input wire logic CURRENT_EN,
   input wire logic [2:0] OUT_RANGE,
   input wire logic BIPOLAR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // detector levels held long enough to cross into this domain
   sequence fault_held;
      (LOOP_FAULT_IN || OVERTEMP_IN) [*5];
   endsequence
   sequence fault_gone;
      !(LOOP_FAULT_IN || OVERTEMP_IN) [*5];
   endsequence
   // clear held long enough to land with slew off
   sequence clr_held;
      CLEAR [*8];
   endsequence
   AST_ALARM_SET: assert property (fault_held |-> FAULT_N_OE)
      else $error("alarm not pulled low");
   AST_ALARM_FREE: assert property (fault_gone |-> !FAULT_N_OE)
      else $error("alarm pulled without cause");
   AST_ALARM_LEVEL: assert property (FAULT_N_OE |-> FAULT_N_O == 1'b0)
      else $error("alarm driven high");
   AST_VOLT_TYPE: assert property (VOLTAGE_EN |-> !OUT_RANGE[2] && !CURRENT_EN)
      else $error("voltage on with current range");
   AST_CURR_TYPE: assert property (CURRENT_EN |-> OUT_RANGE[2] && OUT_RANGE != dac_ctl_pkg::RNG_BAD)
      else $error("current on with voltage range");
   AST_BIPOLAR: assert property ($stable(OUT_RANGE) [*2] |-> BIPOLAR == (OUT_RANGE inside {3'h2, 3'h3}))
      else $error("bipolar decode wrong");
   AST_EN_DEFAULT: assert property ($rose(VOLTAGE_EN) && CLEAR_SELECT && !BIPOLAR |-> ##[0:4] OUT_CODE == 16'h8000)
      else $error("enable default not midscale");
   AST_CLR_CURRENT: assert property (clr_held ##0 CURRENT_EN |-> OUT_CODE == 16'h0000)
      else $error("current clear not at bottom");
   AST_CLR_UNI_SEL1: assert property (clr_held ##0 (CLEAR_SELECT && VOLTAGE_EN && !BIPOLAR) |-> OUT_CODE == 16'h8000)
      else $error("unipolar clear not midscale");
endmodule
bind dac_ctl dac_ctl_sva CHK (.CLK(CLK), .RST(RST), .CLEAR(CLEAR), .CLEAR_SELECT(CLEAR_SELECT),
   .LOOP_FAULT_IN(LOOP_FAULT_IN), .OVERTEMP_IN(OVERTEMP_IN), .FAULT_N_O(FAULT_N_O), .FAULT_N_OE(FAULT_N_OE),
   .OUT_CODE(OUT_CODE), .VOLTAGE_EN(VOLTAGE_EN), .CURRENT_EN(CURRENT_EN), .OUT_RANGE(OUT_RANGE), .BIPOLAR(BIPOLAR));

//--- tb/serial_host_model.sv
/*
 serial host model: frames words on SCLK, SDIN and LATCH and captures SDO.
 assumes one xfer at a time; SCLK rests low between frames, 30 ns period.
*/
`timescale 1ns/1ps
module serial_host_model (
   // link outputs
   output logic SCLK,
   output logic SDIN,
   output logic LATCH,
   // readback
   input wire logic SDO,
   input wire logic SDO_OE
);
   initial begin
      SCLK = 1'b0;
      SDIN = 1'b0;
      LATCH = 1'b0;
   end
   // n edges msb first then latch; n of 0 is an empty latch, other than 24 a framing fault
   task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rx);
      rx = 24'h00_0000;
      for (int i = 0; i < n; i++) begin
         SDIN = w[23 - (i % 24)];
         #15 SCLK = 1'b1;
         rx = {rx[22:0], SDO_OE ? SDO : 1'b0};
         #15 SCLK = 1'b0;
      end
      // data line released: show the inverse, not a held value
      SDIN = ~SDIN;
      #15 LATCH = 1'b1;
      #30 LATCH = 1'b0;
      // spacing before the next word
      #150;
   endtask
endmodule

//--- tb/dac_ctl_tb_top.sv
/*
 testbench for dac_ctl: register writes and readback, ranges, clear, alarm, restart, slew.
 assumes serial_host_model and dac_ctl_sva are compiled before it.
*/
`timescale 1ns/1ps
module dac_ctl_tb_top;
   // pins and scoreboard
   logic clk, rst, clear, clear_select, loop_fault, overtemp;
   wire sclk, sdin, latch, sdo, sdo_oe, fault_n_o, fault_n_oe, volt_en, cur_en, widen, ext_res, bipolar;
   wire [15:0] out_code;
   wire [2:0] out_range;
   wire fault_line = fault_n_oe ? fault_n_o : 1'b1;
   logic [15:0] rv;
   logic [23:0] rx;
   logic [15:0] ccfg [5] = '{16'h1001, 16'h1001, 16'h1003, 16'h9003, 16'h1005};
   logic csel [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   logic [15:0] cexp [5] = '{16'h0000, 16'h8000, 16'h8000, 16'h0000, 16'h0000};
   int bad_count = 0, comparisons = 0, cycles = 0;
   serial_host_model HOST (.SCLK(sclk), .SDIN(sdin), .LATCH(latch), .SDO(sdo), .SDO_OE(sdo_oe));
   dac_ctl DUT (.CLK(clk), .RST(rst), .SCLK(sclk), .SDIN(sdin), .LATCH(latch), .SDO(sdo), .SDO_OE(sdo_oe),
      .CLEAR(clear), .CLEAR_SELECT(clear_select), .LOOP_FAULT_IN(loop_fault), .OVERTEMP_IN(overtemp),
      .FAULT_N_O(fault_n_o), .FAULT_N_OE(fault_n_oe), .OUT_CODE(out_code), .VOLTAGE_EN(volt_en),
      .CURRENT_EN(cur_en), .OUT_RANGE(out_range), .RANGE_WIDEN(widen), .EXT_RESISTOR(ext_res), .BIPOLAR(bipolar));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         conclude();
      end
   end
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      HOST.xfer({a, d}, 24, rx);
   endtask
   task automatic wcfg(input logic [15:0] d);
      wr(dac_ctl_pkg::ADDR_CONFIG, d);
   endtask
   // read request then a no-op word that carries the data out
   task automatic rd(input logic [1:0] sel, output logic [15:0] v);
      HOST.xfer({dac_ctl_pkg::ADDR_READ, 14'h0000, sel}, 24, rx);
      HOST.xfer(24'h00_0000, 24, rx);
      v = rx[15:0];
   endtask
   // pins change at the falling edge, then settle across the synchroniser
   task automatic pins(input logic c, input logic s, input logic lf, input logic ot);
      @(negedge clk);
      clear = c;
      clear_select = s;
      loop_fault = lf;
      overtemp = ot;
      repeat (8) @(negedge clk);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      {rst, clear, clear_select, loop_fault, overtemp} = 5'b10000;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      HOST.xfer(24'h00_0000, 0, rx);
      chk("code", 16'h0000, out_code);
      rd(dac_ctl_pkg::RD_CONFIG, rv);
      chk("cfg", 16'h0000, rv);
      $display("test power_on done");
      for (int r = 0; r < 8; r++) begin
         // code 100 has no range and is never sent
         if (r == 4) continue;
         wcfg(16'h0000);
         wcfg(16'h1000 | 16'(r));
         chk("range", 24'(r), out_range);
         chk("v_en", r < 4, volt_en);
         chk("i_en", r > 4, cur_en);
         chk("bipolar", r == 2 || r == 3, bipolar);
      end
      wcfg(16'h6001);
      chk("widen", 1'b1, widen);
      chk("ext", 1'b1, ext_res);
      chk("off", 1'b0, volt_en);
      rd(dac_ctl_pkg::RD_CONFIG, rv);
      chk("cfg", 16'h6001, rv);
      HOST.xfer({dac_ctl_pkg::ADDR_CONFIG, 16'h0002}, 23, rx);
      HOST.xfer({dac_ctl_pkg::ADDR_CONFIG, 16'h0002}, 25, rx);
      chk("framing", 3'h1, out_range);
      $display("test ranges done");
      pins(0, 1, 0, 0);
      wcfg(16'h1001);
      chk("pin default", 16'h8000, out_code);
      pins(0, 0, 0, 0);
      wcfg(16'h0001);
      wcfg(16'h9001);
      chk("bit default", 16'h8000, out_code);
      wcfg(16'h0003);
      wcfg(16'h1003);
      chk("range default", 16'h8000, out_code);
      $display("test defaults done");
      for (int k = 0; k < 5; k++) begin
         wcfg(16'h0000);
         wcfg(ccfg[k]);
         wr(dac_ctl_pkg::ADDR_DATA, 16'hA5A5);
         chk("data", 16'hA5A5, out_code);
         pins(1, csel[k], 0, 0);
         chk("cleared", cexp[k], out_code);
         wr(dac_ctl_pkg::ADDR_DATA, 16'h1234);
         chk("held", cexp[k], out_code);
         pins(0, csel[k], 0, 0);
         chk("released", cexp[k], out_code);
         HOST.xfer(24'h00_0000, 0, rx);
         chk("restored", 16'hA5A5, out_code);
      end
      rd(dac_ctl_pkg::RD_DATA, rv);
      chk("data rd", 16'hA5A5, rv);
      $display("test clear done");
      pins(0, 0, 1, 0);
      chk("alarm", 1'b0, fault_line);
      rd(dac_ctl_pkg::RD_STATUS, rv);
      chk("status", 16'h0004, rv);
      pins(0, 0, 0, 1);
      rd(dac_ctl_pkg::RD_STATUS, rv);
      chk("status", 16'h0001, rv);
      pins(0, 0, 0, 0);
      chk("alarm", 1'b1, fault_line);
      wr(8'h03, 16'hFFFF);
      rd(dac_ctl_pkg::RD_STATUS, rv);
      chk("status", 16'h0000, rv);
      $display("test alarm done");
      wcfg(16'h1001);
      wr(dac_ctl_pkg::ADDR_DATA, 16'h4321);
      wr(dac_ctl_pkg::ADDR_RESTART, 16'hFFFE);
      chk("no restart", 16'h4321, out_code);
      wr(dac_ctl_pkg::ADDR_RESTART, 16'h0001);
      chk("restart", 20'h0_0000, {out_range, volt_en, out_code});
      rd(dac_ctl_pkg::RD_CONFIG, rv);
      chk("cfg", 16'h0000, rv);
      $display("test restart done");
      wcfg(16'h10F1);
      wr(dac_ctl_pkg::ADDR_DATA, 16'h0400);
      rd(dac_ctl_pkg::RD_STATUS, rv);
      chk("ramp flag", 1'b1, rv[1]);
      chk("ramping", 1'b1, out_code < 16'h0400);
      chk("step", 7'h00, out_code[6:0]);
      repeat (2500) @(negedge clk);
      chk("ramp end", 16'h0400, out_code);
      rd(dac_ctl_pkg::RD_STATUS, rv);
      chk("ramp flag", 1'b0, rv[1]);
      $display("test slew done");
      conclude();
   end
endmodule
